/* File: src/skip_call_pkg.sv */
// Package with instruction types, widths and carrier structs
package skip_call_pkg;
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 6;
  localparam int BIT_SEL_W = 3;
  localparam int HIGH_W = 2;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_TEST_BIT_SKIP_IF_CLEAR = 3'b001,
    OP_TEST_BIT_SKIP_IF_SET = 3'b010,
    OP_CALL_IMMEDIATE = 3'b011,
    OP_CALL_VIA_ACCUMULATOR = 3'b100
  } op_t;

  typedef struct packed {
    op_t op;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] address;
  } instr_t;

  typedef struct packed {
    logic push;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] data;
  } push_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SKIP = 2'b01,
    ST_CALL = 2'b10
  } state_t;
endpackage : skip_call_pkg

/* File: src/bit_tester.sv */
// Selected-bit test for the two skip instructions
`timescale 1ns/10ps
module bit_tester (
  input wire logic [skip_call_pkg::DATA_W-1:0] reg_data,
  input wire logic [skip_call_pkg::BIT_SEL_W-1:0] bit_sel,
  input wire logic want_set,
  output logic skip
);
  always_comb begin
    skip = (reg_data[bit_sel] == want_set);
  end
endmodule : bit_tester

/* File: src/bit_skip_and_call_exec.sv */
// Execution of bit-test-skip and subroutine-call instructions
// How it works
// - Skip next when addressed register bit clear
// - Skip next when addressed register bit set
// - Skip discards fetched instruction, runs no-op
// - Calls push PC plus one, two cycles
// - Immediate call: {buffer[1:0], operand} into PC
// - Accumulator call: {pointer[1:0], accumulator} into PC
`timescale 1ns/10ps
module bit_skip_and_call_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire skip_call_pkg::instr_t instr,
  input wire logic [skip_call_pkg::DATA_W-1:0] reg_data,
  input wire logic [skip_call_pkg::DATA_W-1:0] accumulator,
  input wire logic [skip_call_pkg::DATA_W-1:0] program_high_buffer,
  input wire logic [skip_call_pkg::DATA_W-1:0] table_high_pointer,
  output logic [skip_call_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic [skip_call_pkg::PC_W-1:0] pc,
  output logic busy,
  output logic flush,
  output skip_call_pkg::push_t stack_push
);
  skip_call_pkg::state_t state_r, state_nxt;
  logic [skip_call_pkg::PC_W-1:0] pc_r, pc_nxt;
  logic [skip_call_pkg::SP_W-1:0] sp_r, sp_nxt;
  skip_call_pkg::push_t push_r, push_nxt;
  logic flush_r, flush_nxt;
  logic busy_r, busy_nxt;
  logic [skip_call_pkg::REG_ADDR_W-1:0] addr_r, addr_nxt;
  logic skip_hit;
  logic is_test;

  always_comb begin
    is_test = instr_valid &&
      (instr.op == skip_call_pkg::OP_TEST_BIT_SKIP_IF_CLEAR ||
       instr.op == skip_call_pkg::OP_TEST_BIT_SKIP_IF_SET);
  end

  bit_tester u_bit_tester (
    .reg_data(reg_data),
    .bit_sel(instr.bit_sel),
    .want_set(instr.op == skip_call_pkg::OP_TEST_BIT_SKIP_IF_SET),
    .skip(skip_hit)
  );

  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    push_nxt = push_r;
    push_nxt.push = 1'b0;
    flush_nxt = 1'b0;
    addr_nxt = instr.reg_addr;
    case (state_r)
      skip_call_pkg::ST_RUN: begin
        if (instr_valid) begin
          pc_nxt = pc_r + skip_call_pkg::PC_STEP;
          case (instr.op)
            skip_call_pkg::OP_TEST_BIT_SKIP_IF_CLEAR,
            skip_call_pkg::OP_TEST_BIT_SKIP_IF_SET: begin
              if (is_test && skip_hit) begin
                state_nxt = skip_call_pkg::ST_SKIP;
                flush_nxt = 1'b1;
              end
            end
            skip_call_pkg::OP_CALL_IMMEDIATE: begin
              push_nxt.push = 1'b1;
              push_nxt.sp = sp_r;
              push_nxt.data = pc_r + skip_call_pkg::PC_STEP;
              sp_nxt = sp_r + skip_call_pkg::SP_STEP;
              pc_nxt = {program_high_buffer[skip_call_pkg::HIGH_W-1:0],
                        instr.address};
              state_nxt = skip_call_pkg::ST_CALL;
              flush_nxt = 1'b1;
            end
            skip_call_pkg::OP_CALL_VIA_ACCUMULATOR: begin
              push_nxt.push = 1'b1;
              push_nxt.sp = sp_r;
              push_nxt.data = pc_r + skip_call_pkg::PC_STEP;
              sp_nxt = sp_r + skip_call_pkg::SP_STEP;
              pc_nxt = {table_high_pointer[skip_call_pkg::HIGH_W-1:0],
                        accumulator};
              state_nxt = skip_call_pkg::ST_CALL;
              flush_nxt = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      skip_call_pkg::ST_SKIP: begin
        // No-op slot replaces the discarded instruction
        pc_nxt = pc_r + skip_call_pkg::PC_STEP;
        state_nxt = skip_call_pkg::ST_RUN;
      end
      skip_call_pkg::ST_CALL: begin
        state_nxt = skip_call_pkg::ST_RUN;
      end
      default: begin
        state_nxt = skip_call_pkg::ST_RUN;
      end
    endcase
    // Busy flag registered so the port comes straight from a flip-flop
    busy_nxt = (state_nxt != skip_call_pkg::ST_RUN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= skip_call_pkg::ST_RUN;
      pc_r <= skip_call_pkg::PC_RESET;
      sp_r <= skip_call_pkg::SP_RESET;
      push_r <= '0;
      flush_r <= 1'b0;
      busy_r <= 1'b0;
      addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      push_r <= push_nxt;
      flush_r <= flush_nxt;
      busy_r <= busy_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign reg_addr = addr_r;
  assign pc = pc_r;
  assign busy = busy_r;
  assign flush = flush_r;
  assign stack_push = push_r;
endmodule : bit_skip_and_call_exec

/* File: testbench/bsc_props.sv */
// Assertions for bit-skip and call execution
`timescale 1ns/10ps
module bsc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire skip_call_pkg::instr_t instr,
  input wire logic [7:0] reg_data,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] program_high_buffer,
  input wire logic [7:0] table_high_pointer,
  input wire logic [9:0] pc,
  input wire logic busy,
  input wire logic flush,
  input wire skip_call_pkg::push_t stack_push
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire go = instr_valid && !busy;
  wire hit = reg_data[instr.bit_sel];
  wire clr = go && instr.op == skip_call_pkg::OP_TEST_BIT_SKIP_IF_CLEAR;
  wire sts = go && instr.op == skip_call_pkg::OP_TEST_BIT_SKIP_IF_SET;
  wire imm = go && instr.op == skip_call_pkg::OP_CALL_IMMEDIATE;
  wire acc = go && instr.op == skip_call_pkg::OP_CALL_VIA_ACCUMULATOR;
  wire [9:0] imm_pc = {program_high_buffer[1:0], instr.address};
  wire [9:0] acc_pc = {table_high_pointer[1:0], accumulator};
  property p_clr; clr |=> flush == !$past(hit); endproperty
  a_clr: assert property (p_clr) else $error("clear skip");
  property p_set; sts |=> flush == $past(hit); endproperty
  a_set: assert property (p_set) else $error("set skip");
  property p_nop; (clr && !hit) || (sts && hit) |=> busy ##1
    pc == $past(pc, 2) + 10'h002; endproperty
  a_nop: assert property (p_nop) else $error("skip cycle");
  property p_call; imm || acc |=> busy && stack_push.push &&
    stack_push.data == $past(pc) + 10'h001; endproperty
  a_call: assert property (p_call) else $error("call push");
  property p_imm; imm |=> pc == $past(imm_pc); endproperty
  a_imm: assert property (p_imm) else $error("imm target");
  property p_acc; acc |=> pc == $past(acc_pc); endproperty
  a_acc: assert property (p_acc) else $error("acc target");
  property p_sp; stack_push.push ##1 (imm || acc) |=>
    stack_push.sp == $past(stack_push.sp, 2) + 3'h1; endproperty
  a_sp: assert property (p_sp) else $error("stack step");
endmodule : bsc_props
bind bit_skip_and_call_exec bsc_props props_u (.clk, .rst, .instr_valid,
  .instr, .reg_data, .accumulator, .program_high_buffer,
  .table_high_pointer, .pc, .busy, .flush, .stack_push);

/* File: testbench/bit_skip_and_call_exec_tb.sv */
// Self-checking bench for bit-skip and call execution
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module bit_skip_and_call_exec_tb;
  logic clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, busy, flush, h;
  skip_call_pkg::instr_t instr = '0;
  logic [7:0] reg_data = 8'h5A, accumulator = 8'h00;
  logic [7:0] program_high_buffer = 8'h00, table_high_pointer = 8'h00;
  logic [9:0] pc, exp_pc = 10'h000;
  logic [2:0] exp_sp = 3'h0;
  logic [5:0] reg_addr;
  skip_call_pkg::push_t stack_push;
  int errors = 0, n_compared = 0;
  always #20 clk = ~clk;
  bit_skip_and_call_exec dut_u (.clk, .rst, .instr_valid, .instr, .reg_data,
    .accumulator, .program_high_buffer, .table_high_pointer, .reg_addr,
    .pc, .busy, .flush, .stack_push);
  task automatic issue(skip_call_pkg::op_t op, logic [2:0] b, logic [7:0] a);
    @(posedge clk);
    #1;
    instr = '{op, 6'h2A, b, a};
    instr_valid = 1'h1;
    @(posedge clk);
    #1;
    instr_valid = 1'h0;
  endtask : issue
  task automatic skip_tests();
    issue(skip_call_pkg::OP_NONE, 3'h0, 8'h00);
    exp_pc = exp_pc + 10'h001;
    `CHK("plain pc", exp_pc, pc)
    `CHK("plain flush", 1'h0, flush)
    `CHK("reg addr", 6'h2A, reg_addr)
    for (int k = 0; k < 16; k++) begin
      h = reg_data[k%8] == (k >= 8);
      issue(k < 8 ? skip_call_pkg::OP_TEST_BIT_SKIP_IF_CLEAR :
        skip_call_pkg::OP_TEST_BIT_SKIP_IF_SET, k[2:0], 8'h00);
      `CHK("flush", h, flush)
      `CHK("busy", h, busy)
      exp_pc = exp_pc + 10'h001;
      `CHK("pc", exp_pc, pc)
      if (h) begin
        @(posedge clk);
        #1;
        exp_pc = exp_pc + 10'h001;
        `CHK("skip pc", exp_pc, pc)
      end
    end
  endtask : skip_tests
  task automatic call_tests();
    for (int k = 0; k < 9; k++) begin
      accumulator = 8'hA5 ^ k[7:0];
      program_high_buffer = k[7:0];
      table_high_pointer = ~k[7:0];
      issue(k[0] ? skip_call_pkg::OP_CALL_IMMEDIATE :
        skip_call_pkg::OP_CALL_VIA_ACCUMULATOR, 3'h0, 8'h3C + k[7:0]);
      `CHK("push", 1'h1, stack_push.push)
      `CHK("call busy", 1'h1, busy)
      `CHK("data", exp_pc + 10'h001, stack_push.data)
      `CHK("sp", exp_sp, stack_push.sp)
      exp_pc = k[0] ? {k[1:0], 8'h3C + k[7:0]} : {~k[1:0], 8'hA5 ^ k[7:0]};
      `CHK("target", exp_pc, pc)
      exp_sp = exp_sp + 3'h1;
    end
  endtask : call_tests
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'h0;
    skip_tests();
    call_tests();
    give_verdict();
  end
endmodule : bit_skip_and_call_exec_tb
